// ===== hdl/trc_timer.sv
// trc_timer: 16-bit reload/capture timer with apb registers and interrupt.
// assumes the trigger pin is synchronous to i_clock and apb runs on i_clock.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
// Summary of operation
// - clock-out toggles on overflow or down-count match only while clock-out enable is set.
// - down-count enable in auto-reload mode lets the trigger pin set direction.
// - capture copies count low and high bytes into capture low and high.
// - auto-reload loads capture high and low as the 16-bit count.
// - timer clock is core clock over 6, or over 12 with clock-select set.
// - the twelve-clock option forces divide by 12, ignoring clock-select.
// - counting happens only while run is set; clearing it holds the count.
// - external enable: falling trigger edge captures or reloads per select bit, except in baud or down-count mode.
// - overflow or down-count match sets the overflow flag unless in baud mode.
module trc_timer
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [trc_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_trigger_direction_pin,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  output logic o_clock_out,
  output logic o_irq
);
  import trc_pkg::*;

  typedef struct packed {
    trc_apb_e phase;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] mode;
    logic [15:0] rcap;
    logic [15:0] cnt;
    logic clk_sel;
    logic [5:0] ctrl;
    logic [1:0] stat;
    logic [1:0] en;
    logic trig_prev;
    logic clk_out;
    logic irq;
  } trc_state_s;

  trc_state_s q_ff;
  trc_state_s nxt_q;
  trc_tick_if tk ();

  logic wr;
  logic baud;
  logic dcm;
  logic fall;
  logic ovf;
  logic match;
  logic hit;
  logic [7:0] rd_byte;
  logic [31:0] rd_word;
  logic [1:0] set_ev;

  trc_prescaler u_prescaler
  (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .tk(tk)
  );

  assign tk.div12 = q_ff.ctrl[CTRL_OPT12] | q_ff.clk_sel;
  assign tk.run = q_ff.ctrl[CTRL_RUN];

  always_comb
  begin
    nxt_q = q_ff;
    wr = i_psel & i_penable & i_pwrite & q_ff.pready;
    baud = q_ff.ctrl[CTRL_RXBAUD] | q_ff.ctrl[CTRL_TXBAUD];
    // direction control only in auto-reload mode
    dcm = q_ff.mode[MODE_DOWN_COUNT_ENABLE] & ~q_ff.ctrl[CTRL_CPRL] & ~baud;
    fall = q_ff.trig_prev & ~i_trigger_direction_pin;
    ovf = 1'b0;
    match = 1'b0;
    set_ev = 2'b00;
    hit = 1'b1;
    rd_byte = RST_BYTE;
    rd_word = 32'h0000_0000;
    nxt_q.trig_prev = i_trigger_direction_pin;

    // counting
    if (q_ff.ctrl[CTRL_RUN] && tk.tick)
    begin
      if (dcm && !i_trigger_direction_pin)
      begin
        if (q_ff.cnt == q_ff.rcap)
        begin
          nxt_q.cnt = CNT_MAX;
          match = 1'b1;
        end
        else
        begin
          nxt_q.cnt = q_ff.cnt - 16'h0001;
        end
      end
      else if (q_ff.cnt == CNT_MAX)
      begin
        ovf = 1'b1;
        if (q_ff.ctrl[CTRL_CPRL] && !baud)
        begin
          nxt_q.cnt = 16'h0000;
        end
        else
        begin
          nxt_q.cnt = q_ff.rcap;
        end
      end
      else
      begin
        nxt_q.cnt = q_ff.cnt + 16'h0001;
      end
    end

    // external trigger edge
    if (q_ff.ctrl[CTRL_EXEN] && fall && !dcm)
    begin
      set_ev[STAT_EXT] = 1'b1;
      if (!baud && q_ff.ctrl[CTRL_CPRL])
      begin
        nxt_q.rcap = q_ff.cnt;
      end
      else if (!baud)
      begin
        nxt_q.cnt = q_ff.rcap;
      end
    end

    set_ev[STAT_OVF] = (ovf | match) & ~baud;
    if (q_ff.mode[MODE_OE] && (ovf || match))
    begin
      nxt_q.clk_out = ~q_ff.clk_out;
    end

    // register read mux
    case (i_paddr)
      trc_addr(IDX_MODE): rd_byte = {6'b00_0000, q_ff.mode};
      trc_addr(IDX_RCAP_LO): rd_byte = q_ff.rcap[7:0];
      trc_addr(IDX_RCAP_HI): rd_byte = q_ff.rcap[15:8];
      trc_addr(IDX_CNT_LO): rd_byte = q_ff.cnt[7:0];
      trc_addr(IDX_CNT_HI): rd_byte = q_ff.cnt[15:8];
      trc_addr(IDX_CLK_RATE): rd_byte = {2'b00, q_ff.clk_sel, 5'b0_0000};
      ADDR_CTRL: rd_byte = {2'b00, q_ff.ctrl};
      ADDR_STAT: rd_byte = {6'b00_0000, q_ff.stat};
      ADDR_CLR: rd_byte = RST_BYTE;
      ADDR_EN: rd_byte = {6'b00_0000, q_ff.en};
      default: hit = 1'b0;
    endcase
    rd_word = {24'h00_0000, rd_byte};

    // apb: one wait state, answer from flops
    case (q_ff.phase)
      APB_IDLE:
      begin
        if (i_psel && i_penable)
        begin
          nxt_q.phase = APB_ACK;
          nxt_q.pready = 1'b1;
          nxt_q.pslverr = ~hit;
          nxt_q.prdata = i_pwrite ? 32'h0000_0000 : rd_word;
        end
      end
      APB_ACK:
      begin
        nxt_q.phase = APB_IDLE;
        nxt_q.pready = 1'b0;
        nxt_q.pslverr = 1'b0;
      end
      default:
      begin
        nxt_q.phase = APB_IDLE;
        nxt_q.pready = 1'b0;
      end
    endcase

    // register writes override counting
    if (wr)
    begin
      case (i_paddr)
        trc_addr(IDX_MODE): nxt_q.mode = i_pwdata[1:0];
        trc_addr(IDX_RCAP_LO): nxt_q.rcap[7:0] = i_pwdata[7:0];
        trc_addr(IDX_RCAP_HI): nxt_q.rcap[15:8] = i_pwdata[7:0];
        trc_addr(IDX_CNT_LO): nxt_q.cnt[7:0] = i_pwdata[7:0];
        trc_addr(IDX_CNT_HI): nxt_q.cnt[15:8] = i_pwdata[7:0];
        trc_addr(IDX_CLK_RATE): nxt_q.clk_sel = i_pwdata[CLK_SEL];
        ADDR_CTRL: nxt_q.ctrl = i_pwdata[5:0];
        ADDR_EN: nxt_q.en = i_pwdata[1:0];
        default:
        begin
        end
      endcase
    end

    // sticky status; a new event wins over a clear in the same cycle
    if (wr && i_paddr == ADDR_CLR)
    begin
      nxt_q.stat = (q_ff.stat & ~i_pwdata[1:0]) | set_ev;
    end
    else
    begin
      nxt_q.stat = q_ff.stat | set_ev;
    end
    nxt_q.irq = |(nxt_q.stat & nxt_q.en);
  end

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      q_ff <= '0;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  assign o_pready = q_ff.pready;
  assign o_pslverr = q_ff.pslverr;
  assign o_prdata = q_ff.prdata;
  assign o_clock_out = q_ff.clk_out;
  assign o_irq = q_ff.irq;

  // checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  stop_hold_a: assert property (
    !q_ff.ctrl[CTRL_RUN] && !wr && !(q_ff.ctrl[CTRL_EXEN] && fall)
    |=> $stable(q_ff.cnt))
    else $error("count moved while stopped");

  cap_copy_a: assert property (
    q_ff.ctrl[CTRL_EXEN] && fall && q_ff.ctrl[CTRL_CPRL] && !baud && !wr
    |=> q_ff.rcap == $past(q_ff.cnt))
    else $error("capture did not copy count");

  edge_reload_a: assert property (
    q_ff.ctrl[CTRL_EXEN] && fall && !q_ff.ctrl[CTRL_CPRL] && !dcm && !baud && !wr
    |=> q_ff.cnt == $past(q_ff.rcap))
    else $error("falling edge did not reload");

  ovf_reload_a: assert property (
    ovf && !q_ff.ctrl[CTRL_CPRL] && !wr && !(q_ff.ctrl[CTRL_EXEN] && fall)
    |=> q_ff.cnt == $past(q_ff.rcap))
    else $error("overflow did not reload");

  ovf_flag_a: assert property (
    (ovf || match) && !baud |=> q_ff.stat[STAT_OVF]
    && q_ff.irq == (q_ff.en[STAT_OVF] | (q_ff.en[STAT_EXT] & q_ff.stat[STAT_EXT])))
    else $error("overflow flag not set");

  dn_match_a: assert property (
    dcm && !i_trigger_direction_pin && q_ff.ctrl[CTRL_RUN] && tk.tick
    && q_ff.cnt == q_ff.rcap && !wr |=> q_ff.cnt == CNT_MAX)
    else $error("down-count match did not wrap");

  up_dir_a: assert property (
    dcm && i_trigger_direction_pin && q_ff.ctrl[CTRL_RUN] && tk.tick
    && q_ff.cnt != CNT_MAX && !wr |=> q_ff.cnt == $past(q_ff.cnt) + 16'h0001)
    else $error("up count wrong");

  rate_fast_a: assert property (
    tk.tick && tk.run && !tk.div12 ##1 (tk.run && !tk.div12)[*5] |=> tk.tick)
    else $error("divide-by-6 tick late");

  // with the option set, a clear select bit must not give the six-clock tick
  rate_slow_a: assert property (
    tk.tick && tk.run && q_ff.ctrl[CTRL_OPT12] && !q_ff.clk_sel
    ##1 (tk.run && q_ff.ctrl[CTRL_OPT12])[*5] |=> !tk.tick)
    else $error("twelve-clock option ignored");

  clk_out_a: assert property (
    !q_ff.mode[MODE_OE] |=> $stable(q_ff.clk_out))
    else $error("clock-out moved while disabled");

  mode_rsvd_a: assert property (
    q_ff.pready && i_paddr == trc_addr(IDX_MODE) |-> q_ff.prdata[31:2] == 30'h0)
    else $error("reserved mode bits read non-zero");

  ovf_toggle_a: assert property (
    q_ff.mode[MODE_OE] && (ovf || match)
    |=> q_ff.clk_out != $past(q_ff.clk_out))
    else $error("clock-out did not toggle");

  // bus handshake
  apb_wait_a: assert property (
    q_ff.phase == APB_IDLE && i_psel && i_penable
    |=> q_ff.pready && q_ff.phase == APB_ACK)
    else $error("ready not given after one wait state");

  apb_pulse_a: assert property (
    q_ff.pready
    |=> !q_ff.pready)
    else $error("ready held longer than one cycle");

  slverr_qual_a: assert property (
    q_ff.pslverr
    |-> q_ff.pready)
    else $error("error shown without ready");

  cnt_wr_a: assert property (
    wr && i_paddr == trc_addr(IDX_CNT_HI)
    |=> q_ff.cnt[15:8] == $past(i_pwdata[7:0]))
    else $error("count high byte write lost");

  // flags
  flag_sticky_a: assert property (
    q_ff.stat[STAT_OVF] && !(wr && i_paddr == ADDR_CLR && i_pwdata[STAT_OVF])
    |=> q_ff.stat[STAT_OVF])
    else $error("overflow flag cleared by hardware");

  baud_flag_a: assert property (
    baud && !q_ff.stat[STAT_OVF]
    |=> !q_ff.stat[STAT_OVF])
    else $error("overflow flag set in baud mode");

  ext_flag_a: assert property (
    q_ff.ctrl[CTRL_EXEN] && fall && !dcm
    |=> q_ff.stat[STAT_EXT])
    else $error("external flag not set on falling edge");

  // counting
  dcm_edge_a: assert property (
    dcm && fall && !wr
    |=> $stable(q_ff.rcap) && q_ff.stat[STAT_EXT] == $past(q_ff.stat[STAT_EXT]))
    else $error("trigger edge acted in down-count mode");

  dn_step_a: assert property (
    dcm && !i_trigger_direction_pin && q_ff.ctrl[CTRL_RUN] && tk.tick
    && q_ff.cnt != q_ff.rcap && !wr |=> q_ff.cnt == $past(q_ff.cnt) - 16'h0001)
    else $error("down count wrong");

  cov_ovf_c: cover property (ovf ##1 q_ff.stat[STAT_OVF]);
  cov_cap_c: cover property (q_ff.ctrl[CTRL_EXEN] && fall && q_ff.ctrl[CTRL_CPRL]);
  cov_match_c: cover property (match);
  cov_irq_c: cover property ($rose(q_ff.irq));
  cov_reload_c: cover property (ovf && !q_ff.ctrl[CTRL_CPRL]);
endmodule : trc_timer

// ===== hdl/trc_pkg.sv
// trc_pkg: register map, field positions, reset values and prescale counts
// of the reload/capture timer. assumes a 32-bit apb slave, one word per register.
package trc_pkg;
  localparam int ADDR_W = 12;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE = 8'hC9;
  localparam logic [7:0] IDX_RCAP_LO = 8'hCA;
  localparam logic [7:0] IDX_RCAP_HI = 8'hCB;
  localparam logic [7:0] IDX_CNT_LO = 8'hCC;
  localparam logic [7:0] IDX_CNT_HI = 8'hCD;
  localparam logic [7:0] IDX_CLK_RATE = 8'hDF;
  // control and interrupt registers
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h400;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 12'h404;
  localparam logic [ADDR_W-1:0] ADDR_CLR = 12'h408;
  localparam logic [ADDR_W-1:0] ADDR_EN = 12'h40C;
  // field positions
  localparam int MODE_DOWN_COUNT_ENABLE = 0;
  localparam int MODE_OE = 1;
  localparam int CLK_SEL = 5;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_EXEN = 1;
  localparam int CTRL_CPRL = 2;
  localparam int CTRL_RXBAUD = 3;
  localparam int CTRL_TXBAUD = 4;
  localparam int CTRL_OPT12 = 5;
  localparam int STAT_OVF = 0;
  localparam int STAT_EXT = 1;
  // reset values and limits
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [3:0] PRESCALE_FAST = 4'h6;
  localparam logic [3:0] PRESCALE_SLOW = 4'hC;

  typedef enum logic {APB_IDLE, APB_ACK} trc_apb_e;

  function automatic logic [ADDR_W-1:0] trc_addr(input logic [7:0] idx);
    trc_addr = {2'b00, idx, 2'b00};
  endfunction : trc_addr
endpackage : trc_pkg

// ===== hdl/trc_tick_if.sv
// trc_tick_if: rate select and run request to the prescaler, tick back.
// assumes both ends run on the same clock.
`timescale 1ns/100ps
interface trc_tick_if;
  logic div12;
  logic run;
  logic tick;
  modport src (input div12, input run, output tick);
  modport user (output div12, output run, input tick);
endinterface : trc_tick_if

// ===== hdl/trc_prescaler.sv
// trc_prescaler: one-cycle tick every 6 or 12 core clocks while run is high.
// assumes i_clock is the core clock and i_sys_rst is synchronous.
`timescale 1ns/100ps
module trc_prescaler
  import trc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  trc_tick_if.src tk
);
  typedef struct packed {
    logic [3:0] cnt;
    logic tick;
  } trc_psc_s;

  trc_psc_s q_ff;
  trc_psc_s nxt_q;
  logic [3:0] limit;

  always_comb
  begin
    nxt_q = q_ff;
    limit = tk.div12 ? PRESCALE_SLOW : PRESCALE_FAST;
    nxt_q.tick = 1'b0;
    if (!tk.run)
    begin
      nxt_q.cnt = 4'h0;
    end
    else if (q_ff.cnt >= limit - 4'h1)
    begin
      nxt_q.cnt = 4'h0;
      nxt_q.tick = 1'b1;
    end
    else
    begin
      nxt_q.cnt = q_ff.cnt + 4'h1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      q_ff <= '0;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  assign tk.tick = q_ff.tick;
endmodule : trc_prescaler

// ===== tb/trc_pin_model.sv
// trc_pin_model: far side of the timer, drives the trigger/direction pin
// and counts clock-out toggles. assumes it shares the core clock.
`timescale 1ns/100ps
module trc_pin_model
(
  input wire logic i_clock,
  input wire logic i_clock_out,
  output logic o_pin
);
  int toggles;
  logic last_ff;
  initial
  begin
    o_pin = 1'b1;
    toggles = 0;
    last_ff = 1'b0;
  end
  always @(posedge i_clock)
  begin
    last_ff <= i_clock_out;
    // only known-to-known changes count, so the start before reset adds none
    if ((i_clock_out === 1'b1 && last_ff === 1'b0)
      || (i_clock_out === 1'b0 && last_ff === 1'b1))
      toggles <= toggles + 1;
  end
  // each level held two clocks, above the one-clock minimum
  task automatic fall();
    @(posedge i_clock);
    o_pin <= 1'b0;
    repeat (2) @(posedge i_clock);
    o_pin <= 1'b1;
    @(posedge i_clock);
  endtask : fall
  task automatic set_lvl(input logic v);
    @(posedge i_clock);
    o_pin <= v;
  endtask : set_lvl
endmodule : trc_pin_model

// ===== tb/timer2_reload_capture_counter_tb.sv
// timer2_reload_capture_counter_tb: random and corner tests of the timer over apb.
// assumes the pin model on the trigger pin and one 250 MHz clock.
`timescale 1ns/100ps
module timer2_reload_capture_counter_tb;
  import trc_pkg::*;
  logic clk, rst, psel, pen, pwr, pin, rdy, err, cko, irq, e;
  logic [ADDR_W-1:0] pa;
  logic [31:0] pwd, prd, r, c, v;
  logic [31:0] seed = 32'h07D2B25B;
  int fail_count = 0;
  int cmp_count = 0;
  trc_timer dut_u (.i_clock(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .i_trigger_direction_pin(pin),
    .o_pready(rdy), .o_pslverr(err), .o_prdata(prd), .o_clock_out(cko), .o_irq(irq));
  trc_pin_model pm_u (.i_clock(clk), .i_clock_out(cko), .o_pin(pin));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr
  function automatic logic [ADDR_W-1:0] ra(input logic [7:0] i);
    ra = {2'b00, i, 2'b00};
  endfunction : ra
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x)
    begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic chk_rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    cmp_count++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h..%h", $time, g, lo, hi);
    end
  endtask : chk_rng
  // request held until pready is seen at a rising edge, released at that edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    r = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rdc
  task automatic w16(input logic [7:0] i, input logic [15:0] x);
    wr(ra(i), {24'h0, x[7:0]});
    wr(ra(i + 8'h01), {24'h0, x[15:8]});
  endtask : w16
  task automatic rd16(input logic [7:0] i);
    apb(1'b0, ra(i), 32'h0);
    c[7:0] = r[7:0];
    apb(1'b0, ra(i + 8'h01), 32'h0);
    c[31:8] = {16'h0, r[7:0]};
  endtask : rd16
  task automatic run_for(input logic [31:0] ctl);
    wr(ADDR_CTRL, ctl);
    repeat (120) @(posedge clk);
    wr(ADDR_CTRL, ctl & 32'hFFFF_FFFE);
  endtask : run_for
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (30000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  initial
  begin
    logic [7:0] ids [6];
    int n;
    ids = '{IDX_MODE, IDX_RCAP_LO, IDX_RCAP_HI, IDX_CNT_LO, IDX_CNT_HI, IDX_CLK_RATE};
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    pa = '0;
    pwd = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
      rdc(ra(ids[i]), 32'h0);
    rdc(ADDR_STAT, 32'h0);
    wr(ra(IDX_MODE), 32'hFF);
    rdc(ra(IDX_MODE), 32'h03);
    wr(ra(IDX_CLK_RATE), 32'hFF);
    rdc(ra(IDX_CLK_RATE), 32'h20);
    apb(1'b0, 12'hFF0, 32'h0);
    chk({r[31:1], e}, 32'h1);
    wr(ra(IDX_MODE), 32'h0);
    // divide by 6, by 12 through the select bit, by 12 through the option
    for (int i = 0; i < 3; i++)
    begin
      wr(ra(IDX_CLK_RATE), i == 1 ? 32'h20 : 32'h0);
      w16(IDX_CNT_LO, 16'h0);
      run_for(i == 2 ? 32'h21 : 32'h1);
      rd16(IDX_CNT_LO);
      chk_rng(c, i == 0 ? 19 : 9, i == 0 ? 22 : 11);
      v = c;
      rd16(IDX_CNT_LO);
      chk(c, v);
    end
    seed = lfsr(seed);
    v = {17'h0, seed[14:0]};
    w16(IDX_RCAP_LO, v[15:0]);
    w16(IDX_CNT_LO, 16'hFFF0);
    wr(ra(IDX_CLK_RATE), 32'h0);
    wr(ra(IDX_MODE), 32'h2);
    wr(ADDR_EN, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    wr(ADDR_CTRL, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rd16(IDX_CNT_LO);
    chk_rng(c, v, v + 3);
    chk(pm_u.toggles, 32'h1);
    wr(ADDR_EN, 32'h0);
    rdc(ADDR_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_CLR, 32'h1);
    rdc(ADDR_STAT, 32'h0);
    seed = lfsr(seed);
    w16(IDX_CNT_LO, seed[15:0]);
    wr(ADDR_EN, 32'h2);
    wr(ADDR_CTRL, 32'h6);
    pm_u.fall();
    chk({31'h0, irq}, 32'h1);
    rd16(IDX_RCAP_LO);
    chk(c, {16'h0, seed[15:0]});
    wr(ADDR_CLR, 32'h2);
    w16(IDX_RCAP_LO, seed[31:16]);
    wr(ADDR_CTRL, 32'h2);
    pm_u.fall();
    rd16(IDX_CNT_LO);
    chk(c, {16'h0, seed[31:16]});
    wr(ADDR_CTRL, 32'h0);
    wr(ra(IDX_MODE), 32'h1);
    w16(IDX_RCAP_LO, 16'h0);
    w16(IDX_CNT_LO, 16'h1000);
    pm_u.set_lvl(1'b0);
    run_for(32'h1);
    rd16(IDX_CNT_LO);
    chk_rng(c, 32'h1000 - 22, 32'h1000 - 19);
    v = c;
    pm_u.set_lvl(1'b1);
    run_for(32'h1);
    rd16(IDX_CNT_LO);
    chk_rng(c, v + 19, v + 22);
    // baud mode: overflow reloads but leaves the overflow flag clear
    wr(ADDR_CLR, 32'h3);
    seed = lfsr(seed);
    v = {17'h0, seed[14:0]};
    w16(IDX_RCAP_LO, v[15:0]);
    w16(IDX_CNT_LO, 16'hFFF8);
    run_for(32'h19);
    rd16(IDX_CNT_LO);
    chk_rng(c, v + 11, v + 14);
    rdc(ADDR_STAT, 32'h0);
    finish_test();
  end
endmodule : timer2_reload_capture_counter_tb
